// >>> rtl/dch_pkg.sv
// Constants, types and timing figures shared by the DDR2 command host.
package dch_pkg;
	localparam int AXI_AW = 4;
	localparam int CLK_PERIOD_NS = 10;
	// Least times round up, the longest time rounds down.
	localparam int T_AOFD_NS = 25;
	localparam int T_MOD_MAX_NS = 12;
	localparam int T_RCD_NS = 15;
	localparam int T_RC_NS = 55;
	localparam int T_RRD_NS = 10;
	localparam int T_RFC_NS = 105;
	localparam int T_XSNR_NS = 115;
	localparam int T_XSRD_NS = 2000;
	localparam int T_CKSTAB_NS = 100;
	localparam logic [7:0] C_AOFD = 8'((T_AOFD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] C_MOD_MAX = 8'((T_MOD_MAX_NS < 2 * CLK_PERIOD_NS) ? 1 : T_MOD_MAX_NS / CLK_PERIOD_NS);
	localparam logic [7:0] C_RCD = 8'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] C_RC = 8'((T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] C_RRD = 8'((T_RRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] C_RFC = 8'((T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] C_XSNR = 8'((T_XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] C_XSRD = 8'((T_XSRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] C_XSRD_REST = C_XSRD - C_XSNR;
	localparam logic [7:0] C_CKSTAB = 8'((T_CKSTAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] C_SR_CK = 8'h01;
	// Register offsets and field positions.
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_CFG = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h8;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BANK_LSB = 4;
	localparam int CMD_AP_BIT = 8;
	localparam int CMD_ADDR_LSB = 16;
	localparam int CFG_ODT_BIT = 0;
	localparam int CFG_AL_LSB = 4;
	localparam int STAT_ERR_BIT = 3;
	localparam logic CFG_ODT_RST = 1'b0;
	localparam logic [2:0] CFG_AL_RST = 3'h0;
	// Software command codes.
	localparam logic [3:0] OP_ACT = 4'h1;
	localparam logic [3:0] OP_RD = 4'h2;
	localparam logic [3:0] OP_WR = 4'h3;
	localparam logic [3:0] OP_PREA = 4'h4;
	localparam logic [3:0] OP_REF = 4'h5;
	localparam logic [3:0] OP_SRE = 4'h6;
	localparam logic [3:0] OP_SRX = 4'h7;
	localparam logic [3:0] OP_EMR = 4'h8;
	localparam int ADDR_A10 = 10;
	localparam logic [12:0] ADDR_PREA_ALL = 13'h0400;
	localparam logic [1:0] EMR1_BA = 2'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [6:0]
	{
		ST_IDLE = 7'h01,
		ST_ODT_OFF = 7'h02,
		ST_MRS_WAIT = 7'h04,
		ST_SR = 7'h08,
		ST_CK_WAIT = 7'h10,
		ST_XSNR = 7'h20,
		ST_XSRD = 7'h40
	} dch_state_t;
	typedef enum logic [2:0]
	{
		PC_NOP, PC_ACT, PC_RD, PC_WR, PC_PREA, PC_REF, PC_SRE, PC_EMR
	} dch_pin_cmd_t;
endpackage

// >>> rtl/dch_timer.sv
// Reloadable down counter that flags when a wait has run out.
`timescale 1ns/1ns
`default_nettype none
module dch_timer
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic [7:0] value,
	output logic done
);
	import dch_pkg::*;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	// Load wins over counting; the count rests at zero.
	always_comb
	begin
		cnt_next = cnt_reg;
		if (load)
			cnt_next = value;
		else if (cnt_reg != 8'h00)
			cnt_next = cnt_reg - 8'h01;
	end

	// Count register.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= cnt_next;
	end

	assign done = (cnt_reg == 8'h00);
endmodule
`default_nettype wire

// >>> rtl/dch_pin_drv.sv
// Output flops that turn a command code into the memory pin levels.
`timescale 1ns/1ns
`default_nettype none
module dch_pin_drv
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire dch_pkg::dch_pin_cmd_t cmd,
	input wire logic cke_in,
	input wire logic odt_in,
	input wire logic ck_in,
	input wire logic [1:0] ba_in,
	input wire logic [12:0] addr_in,
	output logic ddr_ck_en,
	output logic ddr_cke,
	output logic ddr_cs_n,
	output logic ddr_ras_n,
	output logic ddr_cas_n,
	output logic ddr_we_n,
	output logic [1:0] ddr_ba,
	output logic [12:0] ddr_addr,
	output logic ddr_odt
);
	import dch_pkg::*;
	logic [3:0] pins_next;

	// Returns chip select, row strobe, column strobe and write enable.
	function automatic logic [3:0] dch_encode(input dch_pin_cmd_t c);
		logic [3:0] r;
		r = 4'h7;
		case (c)
			PC_ACT: r = 4'h3;
			PC_RD: r = 4'h5;
			PC_WR: r = 4'h4;
			PC_PREA: r = 4'h2;
			PC_REF: r = 4'h1;
			PC_SRE: r = 4'h1;
			PC_EMR: r = 4'h0;
			default: r = 4'h7;
		endcase
		return r;
	endfunction

	always_comb
	begin
		pins_next = dch_encode(cmd);
	end

	// Registers every pin; reset deselects the device with CKE low.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ddr_ck_en <= 1'b1;
			ddr_cke <= 1'b0;
			{ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= 4'hF;
			ddr_ba <= 2'h0;
			ddr_addr <= 13'h0000;
			ddr_odt <= 1'b0;
		end
		else
		begin
			ddr_ck_en <= ck_in;
			ddr_cke <= cke_in;
			{ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= pins_next;
			ddr_ba <= ba_in;
			ddr_addr <= addr_in;
			ddr_odt <= odt_in;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/dch_top.sv
// DDR2 command host: AXI4-Lite registers, command sequencer and pin timing.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dch_top
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [dch_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dch_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic ddr_ck_en,
	output logic ddr_cke,
	output logic ddr_cs_n,
	output logic ddr_ras_n,
	output logic ddr_cas_n,
	output logic ddr_we_n,
	output logic [1:0] ddr_ba,
	output logic [12:0] ddr_addr,
	output logic ddr_odt
);
	import dch_pkg::*;

	// --------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------
	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [3:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
	logic [1:0] bresp_next, rresp_next;
	logic [31:0] rdata_next;
	logic wr_fire;
	logic [31:0] wmask, cmd_word, cfg_word, stat_word;
	dch_state_t state_reg, state_next;
	logic pend_reg, pend_next, ap_reg, ap_next, err_reg, err_next;
	logic need_ref_reg, need_ref_next, odt_en_reg, odt_en_next;
	logic [3:0] op_reg, op_next, act_reg, act_next;
	logic [1:0] bank_reg, bank_next;
	logic [12:0] addr_reg, addr_next;
	logic [2:0] al_reg, al_next;
	logic [7:0] odt_low_cnt_reg, odt_low_cnt_next;
	dch_pin_cmd_t pc;
	logic [1:0] issue_ba;
	logic [12:0] issue_addr;
	logic cke_req, odt_req, ck_run, refuse;
	logic gen_load, rrd_load, rfc_load, rcd_load;
	logic [3:0] rc_load, rc_done;
	logic [7:0] gen_val, rcd_val;
	logic gen_done, rrd_done, rfc_done, rcd_done;

	// Byte-lane mask from write strobes.
	function automatic logic [31:0] dch_mask(input logic [3:0] s);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
			m[i*8 +: 8] = {8{s[i]}};
		return m;
	endfunction

	// True for the three mapped register words.
	function automatic logic dch_mapped(input logic [3:0] a);
		return (a == ADDR_CMD) || (a == ADDR_CFG) || (a == ADDR_STAT);
	endfunction

	// --------------------------------------------------------------
	// AXI4-Lite slave
	// --------------------------------------------------------------
	assign wmask = dch_mask(wstrb_reg);
	assign cmd_word = {3'h0, addr_reg, 7'h00, ap_reg, 2'h0, bank_reg, op_reg};
	assign cfg_word = {25'h0, al_reg, 3'h0, odt_en_reg};
	assign stat_word = {22'h0, cke_req, odt_req, act_reg, err_reg, need_ref_reg, state_reg == ST_SR, pend_reg};

	// Address and data are held separately; the write fires once both are in.
	always_comb
	begin
		aw_hold_next = aw_hold_reg;
		awaddr_next = awaddr_reg;
		w_hold_next = w_hold_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = s_axi_bvalid;
		bresp_next = s_axi_bresp;
		rvalid_next = s_axi_rvalid;
		rdata_next = s_axi_rdata;
		rresp_next = s_axi_rresp;
		wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_next = 1'b1;
			awaddr_next = {s_axi_awaddr[3:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			bvalid_next = 1'b0;
		if (wr_fire)
		begin
			bvalid_next = 1'b1;
			bresp_next = dch_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
		end
		if (s_axi_rvalid && s_axi_rready)
			rvalid_next = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_next = 1'b1;
			rresp_next = dch_mapped({s_axi_araddr[3:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
			unique case ({s_axi_araddr[3:2], 2'b00})
				ADDR_CMD: rdata_next = cmd_word;
				ADDR_CFG: rdata_next = cfg_word;
				ADDR_STAT: rdata_next = stat_word;
				default: rdata_next = 32'h0000_0000;
			endcase
		end
		awready_next = !aw_hold_next;
		wready_next = !w_hold_next;
		arready_next = !rvalid_next;
	end

	// Bus registers.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			w_hold_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			aw_hold_reg <= aw_hold_next;
			awaddr_reg <= awaddr_next;
			w_hold_reg <= w_hold_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			s_axi_awready <= awready_next;
			s_axi_wready <= wready_next;
			s_axi_bvalid <= bvalid_next;
			s_axi_bresp <= bresp_next;
			s_axi_arready <= arready_next;
			s_axi_rvalid <= rvalid_next;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rresp_next;
		end
	end

	// --------------------------------------------------------------
	// Command sequencer
	// --------------------------------------------------------------
	// latency shortens row wait
	assign rcd_val = (8'(al_reg) >= C_RCD) ? 8'h00 : C_RCD - 8'(al_reg);

	// Register writes first, then the state step; a refusal sets the error last so it wins.
	always_comb
	begin
		state_next = state_reg;
		pend_next = pend_reg;
		op_next = op_reg;
		bank_next = bank_reg;
		ap_next = ap_reg;
		addr_next = addr_reg;
		err_next = err_reg;
		need_ref_next = need_ref_reg;
		odt_en_next = odt_en_reg;
		al_next = al_reg;
		act_next = act_reg;
		pc = PC_NOP;
		issue_ba = bank_reg;
		issue_addr = addr_reg;
		gen_load = 1'b0;
		gen_val = 8'h00;
		rrd_load = 1'b0;
		rfc_load = 1'b0;
		rcd_load = 1'b0;
		rc_load = 4'h0;
		refuse = 1'b0;
		if (wr_fire && awaddr_reg == ADDR_CFG)
		begin
			odt_en_next = 1'(((cfg_word & ~wmask) | (wdata_reg & wmask)) >> CFG_ODT_BIT);
			al_next = 3'(((cfg_word & ~wmask) | (wdata_reg & wmask)) >> CFG_AL_LSB);
		end
		if (wr_fire && awaddr_reg == ADDR_STAT && wmask[STAT_ERR_BIT] && wdata_reg[STAT_ERR_BIT])
			err_next = 1'b0;
		if (wr_fire && awaddr_reg == ADDR_CMD)
		begin
			if (pend_reg)
				refuse = 1'b1;
			else
			begin
				pend_next = 1'b1;
				op_next = wdata_reg[CMD_OP_LSB +: 4];
				bank_next = wdata_reg[CMD_BANK_LSB +: 2];
				ap_next = wdata_reg[CMD_AP_BIT];
				addr_next = wdata_reg[CMD_ADDR_LSB +: 13];
			end
		end
		unique case (state_reg)
			ST_IDLE:
				if (pend_reg)
				begin
					unique case (op_reg)
						OP_ACT:
							if (act_reg[bank_reg])
								refuse = 1'b1;
							else if (rc_done[bank_reg] && rrd_done && rfc_done)
							begin
								pc = PC_ACT;
								act_next[bank_reg] = 1'b1;
								rc_load[bank_reg] = 1'b1;
								rrd_load = 1'b1;
								rcd_load = 1'b1;
								pend_next = 1'b0;
							end
						OP_RD, OP_WR:
							if (!act_reg[bank_reg])
								refuse = 1'b1;
							else if (rcd_done)
							begin
								pc = (op_reg == OP_RD) ? PC_RD : PC_WR;
								issue_addr[ADDR_A10] = ap_reg;
								if (ap_reg)
									act_next[bank_reg] = 1'b0;
								pend_next = 1'b0;
							end
						OP_PREA:
						begin
							pc = PC_PREA;
							issue_addr = ADDR_PREA_ALL;
							act_next = 4'h0;
							pend_next = 1'b0;
						end
						OP_REF:
							if (act_reg != 4'h0)
								refuse = 1'b1;
							else if (rfc_done)
							begin
								pc = PC_REF;
								rfc_load = 1'b1;
								need_ref_next = 1'b0;
								pend_next = 1'b0;
							end
						OP_EMR:
							if (act_reg != 4'h0)
								refuse = 1'b1;
							else
							begin
								state_next = ST_ODT_OFF;
								gen_load = 1'b1;
								gen_val = C_AOFD;
							end
						OP_SRE:
							if (act_reg != 4'h0 || need_ref_reg)
								refuse = 1'b1;
							else if (rfc_done)
							begin
								state_next = ST_ODT_OFF;
								gen_load = 1'b1;
								gen_val = C_AOFD;
							end
						default: refuse = 1'b1;
					endcase
				end
			ST_ODT_OFF:
				if (gen_done)
				begin
					gen_load = 1'b1;
					if (op_reg == OP_EMR)
					begin
						pc = PC_EMR;
						issue_ba = EMR1_BA;
						gen_val = C_MOD_MAX;
						state_next = ST_MRS_WAIT;
					end
					else
					begin
						pc = PC_SRE;
						gen_val = C_SR_CK;
						state_next = ST_SR;
						pend_next = 1'b0;
					end
				end
			ST_MRS_WAIT:
				if (gen_done)
				begin
					state_next = ST_IDLE;
					pend_next = 1'b0;
				end
			ST_SR:
				if (pend_reg)
				begin
					if (op_reg == OP_SRX)
					begin
						state_next = ST_CK_WAIT;
						gen_load = 1'b1;
						gen_val = C_CKSTAB;
						pend_next = 1'b0;
					end
					else
						refuse = 1'b1;
				end
			ST_CK_WAIT:
				if (gen_done)
				begin
					state_next = ST_XSNR;
					gen_load = 1'b1;
					gen_val = C_XSNR;
				end
			ST_XSNR:
				if (gen_done)
				begin
					state_next = ST_XSRD;
					gen_load = 1'b1;
					gen_val = C_XSRD_REST;
				end
			ST_XSRD:
				if (gen_done)
				begin
					state_next = ST_IDLE;
					need_ref_next = 1'b1;
				end
		endcase
		if (refuse)
		begin
			if (!(wr_fire && awaddr_reg == ADDR_CMD))
				pend_next = 1'b0;
			err_next = 1'b1;
		end
		cke_req = !(state_next == ST_SR || state_next == ST_CK_WAIT);
		odt_req = odt_en_reg && (state_next == ST_IDLE);
		ck_run = !(state_reg == ST_SR && state_next == ST_SR && gen_done);
		odt_low_cnt_next = odt_req ? 8'h00 : (odt_low_cnt_reg == 8'hFF) ? odt_low_cnt_reg : odt_low_cnt_reg + 8'h01;
	end

	// Sequencer registers.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= ST_IDLE;
			pend_reg <= 1'b0;
			op_reg <= 4'h0;
			bank_reg <= 2'h0;
			ap_reg <= 1'b0;
			addr_reg <= 13'h0000;
			err_reg <= 1'b0;
			need_ref_reg <= 1'b0;
			odt_en_reg <= CFG_ODT_RST;
			al_reg <= CFG_AL_RST;
			act_reg <= 4'h0;
			odt_low_cnt_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			pend_reg <= pend_next;
			op_reg <= op_next;
			bank_reg <= bank_next;
			ap_reg <= ap_next;
			addr_reg <= addr_next;
			err_reg <= err_next;
			need_ref_reg <= need_ref_next;
			odt_en_reg <= odt_en_next;
			al_reg <= al_next;
			act_reg <= act_next;
			odt_low_cnt_reg <= odt_low_cnt_next;
		end
	end

	// --------------------------------------------------------------
	// Timers and pins
	// --------------------------------------------------------------
	dch_timer u_gen (.aclk(aclk), .aresetn(aresetn), .load(gen_load), .value(gen_val), .done(gen_done));
	dch_timer u_rrd (.aclk(aclk), .aresetn(aresetn), .load(rrd_load), .value(C_RRD), .done(rrd_done));
	dch_timer u_rfc (.aclk(aclk), .aresetn(aresetn), .load(rfc_load), .value(C_RFC), .done(rfc_done));
	dch_timer u_rcd (.aclk(aclk), .aresetn(aresetn), .load(rcd_load), .value(rcd_val), .done(rcd_done));

	for (genvar b = 0; b < 4; b++)
	begin : g_rc
		dch_timer u_rc (.aclk(aclk), .aresetn(aresetn), .load(rc_load[b]), .value(C_RC), .done(rc_done[b]));
	end

	dch_pin_drv u_pins
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.cmd(pc),
		.cke_in(cke_req),
		.odt_in(odt_req),
		.ck_in(ck_run),
		.ba_in(issue_ba),
		.addr_in(issue_addr),
		.ddr_ck_en(ddr_ck_en),
		.ddr_cke(ddr_cke),
		.ddr_cs_n(ddr_cs_n),
		.ddr_ras_n(ddr_ras_n),
		.ddr_cas_n(ddr_cas_n),
		.ddr_we_n(ddr_we_n),
		.ddr_ba(ddr_ba),
		.ddr_addr(ddr_addr),
		.ddr_odt(ddr_odt)
	);

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_sre;
		pc == PC_SRE;
	endsequence
	sequence s_exit;
		state_reg == ST_CK_WAIT && gen_done;
	endsequence

	a_act_bank_idle: assert property (pc == PC_ACT |-> !act_reg[issue_ba] && rc_done[issue_ba] && rrd_done)
		else $error("activate to an open or too recent bank");
	a_access_open: assert property (pc inside {PC_RD, PC_WR} |-> act_reg[issue_ba] && rcd_done)
		else $error("access to a closed bank or before row delay");
	a_ref_spacing: assert property (pc inside {PC_REF, PC_ACT} |-> rfc_done)
		else $error("command inside refresh cycle time");
	a_emr_odt_quiet: assert property (pc == PC_EMR |-> odt_low_cnt_reg >= C_AOFD && !odt_req)
		else $error("mode write before termination off delay");
	a_mod_window: assert property (pc == PC_EMR |=> (state_reg == ST_MRS_WAIT && cke_req && !odt_req) ##[1:16] state_reg == ST_IDLE)
		else $error("mode update window not held");
	a_sre_odt_off: assert property (s_sre |-> odt_low_cnt_reg >= C_AOFD && !cke_req)
		else $error("self refresh entry with termination on");
	a_sre_need_ref: assert property (s_sre |-> !need_ref_reg)
		else $error("self refresh reentry without refresh");
	a_ck_stop_late: assert property (s_sre |-> ck_run [*2])
		else $error("clock stopped too early after entry");
	a_exit_nops: assert property (s_exit |-> (pc == PC_NOP && cke_req) ##1 (pc == PC_NOP && cke_req) [*8])
		else $error("command during self refresh exit delay");
	a_xsrd_hold: assert property (state_reg == ST_XSRD |-> cke_req && !ddr_odt && pc == PC_NOP)
		else $error("exit period not held");
	a_refuse_err: assert property (refuse |=> err_reg)
		else $error("refused command not flagged");
endmodule
`default_nettype wire

// >>> sim/dch_mem_model.sv
// Behavioural DDR2 device that decodes the command pins of the host.
`timescale 1ns/1ns
`default_nettype none
module dch_mem_model
(
	input wire logic aclk,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] ba,
	input wire logic [12:0] addr,
	input wire logic odt,
	output logic [3:0] open_b,
	output logic in_sr,
	output logic [1:0] rtt,
	output logic [7:0] viol,
	output logic [1:0] drv,
	output logic [1:0] term
);
	logic [3:0] c;
	logic dqs_n_off;
	assign c = {ras_n, cas_n, we_n, addr[10]};
	initial {open_b, in_sr, rtt, viol, drv, dqs_n_off} = '0;
	assign term = {odt && !in_sr, odt && !in_sr && !dqs_n_off};
	// Each command acts at its edge; faults of the host are counted.
	always @(posedge aclk)
	begin
		if (in_sr)
		begin
			in_sr <= !cke;
			viol <= viol + {7'h0, odt};
		end
		else if (!cs_n && !cke && c[3:1] == 3'b001)
		begin
			in_sr <= 1'b1;
			viol <= viol + {7'h0, odt || open_b != 4'h0};
		end
		else if (!cs_n && c[3:1] == 3'b011)
		begin
			viol <= viol + {7'h0, open_b[ba]};
			open_b[ba] <= 1'b1;
		end
		else if (!cs_n && c[3:2] == 2'b10)
		begin
			viol <= viol + {7'h0, !open_b[ba]};
			open_b[ba] <= open_b[ba] && !c[0];
		end
		else if (!cs_n && c == 4'b0101)
			open_b <= 4'h0;
		else if (!cs_n && c[3:1] == 3'b000 && ba == 2'h1)
		begin
			rtt <= {addr[6], addr[2]};
			dqs_n_off <= addr[10];
			if (addr[9:7] == 3'b000 || addr[9:7] == 3'b001 || addr[9:7] == 3'b010)
				drv <= addr[8:7];
		end
	end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the DDR2 command host.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import dch_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, open_b, ob;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, ddr_ba, rtt, drv, term;
	logic ddr_ck_en, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_odt, in_sr;
	logic [12:0] ddr_addr;
	logic [7:0] viol;
	int fails = 0, comparisons = 0;
	// Free-running 100 MHz clock.
	always #5 aclk = ~aclk;
	dch_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ddr_ck_en, .ddr_cke, .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n, .ddr_ba, .ddr_addr, .ddr_odt);
	dch_mem_model mem (.aclk, .cke(ddr_cke), .cs_n(ddr_cs_n), .ras_n(ddr_ras_n), .cas_n(ddr_cas_n),
		.we_n(ddr_we_n), .ba(ddr_ba), .addr(ddr_addr), .odt(ddr_odt), .open_b, .in_sr, .rtt, .viol,
		.drv, .term);
	task automatic report_and_stop();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Register write: address and data offered together, each dropped when taken.
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Issues a command, waits until it is no longer pending, checks error and open banks, clears error.
	task automatic cmd(input logic [3:0] op, input logic [1:0] b, input logic ap, input logic [12:0] ad,
		input logic e);
		logic [31:0] s;
		logic [1:0] r;
		wr(ADDR_CMD, {3'h0, ad, 7'h0, ap, 2'h0, b, op}, r);
		s = 32'h1;
		while (s[0])
			rd(ADDR_STAT, s, r);
		chk(32'({s[STAT_ERR_BIT], s[7:4]}), 32'({e, ob}));
		chk(32'(open_b), 32'(ob));
		wr(ADDR_STAT, 32'h8, r);
	endtask
	// Cuts a hang short.
	initial
	begin
		repeat (60000) @(posedge aclk);
		fails++;
		report_and_stop();
	end
	initial
	begin
		logic [31:0] d, q;
		logic [1:0] r, b;
		logic [3:0] op;
		logic [12:0] ad;
		logic e;
		void'($urandom(32'h126B1F96));
		ob = 4'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_CFG, d, r);
		chk(d, 32'h0);
		wr(4'hC, 32'h0, r);
		chk(32'(r), 32'(RESP_SLVERR));
		rd(4'hC, d, r);
		chk({d[29:0], r}, 32'(RESP_SLVERR));
		d = 32'($urandom_range(0, 6)) << CFG_AL_LSB | 32'h1;
		wr(ADDR_CFG, d, r);
		rd(ADDR_CFG, q, r);
		chk(32'(q[6:0]), d);
		for (int i = 0; i < 30; i++)
		begin
			b = 2'($urandom);
			op = 4'($urandom_range(1, 4));
			e = (op == OP_ACT) ? ob[b] : (op != OP_PREA && !ob[b]);
			d[0] = 1'($urandom);
			if (op == OP_ACT) ob[b] = 1'b1;
			if ((op == OP_RD || op == OP_WR) && d[0]) ob[b] = 1'b0;
			if (op == OP_PREA) ob = 4'h0;
			cmd(op, b, d[0], 13'($urandom_range(0, 511)), e);
		end
		ob = 4'h0;
		cmd(OP_PREA, 2'h2, 1'b0, 13'h0, 1'b0);
		cmd(OP_EMR, 2'h0, 1'b0, 13'h0080, 1'b0);
		chk(32'(drv), 32'h1);
		ad = 13'($urandom) & 13'h1C7F;
		cmd(OP_EMR, 2'h0, 1'b0, ad, 1'b0);
		chk(32'(rtt), 32'({ad[6], ad[2]}));
		chk(32'({drv, term}), 32'({3'h1, !ad[10]}));
		cmd(OP_SRE, 2'h0, 1'b0, 13'h0, 1'b0);
		chk(32'({in_sr, ddr_cke, ddr_odt, ddr_ck_en, term}), 32'h20);
		cmd(OP_ACT, 2'h1, 1'b0, 13'h0, 1'b1);
		cmd(OP_SRX, 2'h0, 1'b0, 13'h0, 1'b0);
		d = 32'h0;
		while (!d[2])
			rd(ADDR_STAT, d, r);
		chk(32'({in_sr, ddr_cke, ddr_ck_en, d[2:1]}), 32'hE);
		cmd(OP_SRE, 2'h0, 1'b0, 13'h0, 1'b1);
		cmd(OP_REF, 2'h0, 1'b0, 13'h0, 1'b0);
		chk(32'(viol), 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
